// ===== core/dao_pkg.sv
// Purpose: Shared constants and types for the dual converter output and power block
// Assumes: 40 MHz system clock, four-level format pin already resolved to two bits
// Notes: Offsets are byte addresses on a 32-bit classic Wishbone slave
package dao_pkg;
	// ==========================================================
	// Data path
	localparam int DATA_W = 14;
	localparam int RAW_W = 16;
	localparam logic signed [RAW_W-1:0] RAW_MAX = 16'sh1FFF;
	localparam logic signed [RAW_W-1:0] RAW_MIN = 16'shE000;
	localparam logic [DATA_W-1:0] CODE_POS_FULL = 14'h1FFF;
	localparam logic [DATA_W-1:0] CODE_NEG_FULL = 14'h2000;
	localparam logic [DATA_W-1:0] CODE_MSB_FLIP = 14'h2000;
	// ==========================================================
	// Four-level format and stabilizer pin
	localparam logic [1:0] MODE_GND = 2'h0;
	localparam logic [1:0] MODE_THIRD = 2'h1;
	localparam logic [1:0] MODE_TWO_THIRD = 2'h2;
	localparam logic [1:0] MODE_SUPPLY = 2'h3;
	// ==========================================================
	// Register map
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] ADR_STATUS = 8'h04;
	localparam logic [ADR_W-1:0] ADR_WORD_A = 8'h08;
	localparam logic [ADR_W-1:0] ADR_WORD_B = 8'h0C;
	localparam int CTRL_HS_BIT = 0;
	localparam logic CTRL_HS_RST = 1'b1;
	localparam int ST_PWR_A = 0;
	localparam int ST_PWR_B = 2;
	localparam int ST_VALID = 4;
	localparam int ST_LOCK = 6;
	localparam int ST_SLOW = 8;
	localparam int ST_DCS = 10;
	localparam int ST_TWOS = 11;
	localparam int ST_SWAP = 12;
	localparam int WORD_OF_BIT = 14;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int SLEEP_WAKE_US = 700;
	localparam int SLEEP_WAKE_CYC = (SLEEP_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLK_STOP_NS = 1000;
	localparam int CLK_STOP_CYC = CLK_STOP_NS / CLK_PERIOD_NS;
	localparam int PER_W = 8;
	localparam int WAKE_W = 16;
	localparam int LOCK_EDGES = 100;
	localparam int NAP_WAKE_EDGES = 100;
	// ==========================================================
	// Per-channel power state
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_NAP = 2'b01,
		PWR_SLEEP = 2'b11,
		PWR_WAKE = 2'b10
	} dao_pwr_t;
endpackage

// ===== core/dao_top.sv
// Purpose: Output coding, overflow, strobe, output disable, power modes and bus swap
// Assumes: Sample clocks and pins are asynchronous and resynchronised to clk_i
// Notes: Tri-state pins are split into value and active-low enable
// Contract
// R1 - Other party keeps sample clock between 1 Msps and the grade's maximum rate.
// R2 - With stabilizer on, sample only on rising edge; falling edge is regenerated.
// R3 - With stabilizer on, accept 40-60% duty, produce internal 50% phase.
// R4 - After a long clock stop, stabilizer needs a hundred edges to relock.
// R5 - With stabilizer off, the source keeps duty within 50% plus or minus 5%.
// R6 - Four-level pin selects binary or two's complement and stabilizer on or off.
// R7 - Zero input is midscale binary or zero two's complement; overrange clamps.
// R8 - High-speed grade: shared overflow flag high when either channel overranges.
// R9 - Shared overflow flag disabled while channel A naps or sleeps.
// R10 - Low-speed grade: each channel drives its own overflow flag.
// R11 - Delayed copy of channel B clock is a strobe; capture on its falling edge.
// R12 - Strobe disabled while channel B naps or sleeps.
// R13 - Output disable high floats that channel's data and overflow outputs.
// R14 - Other party toggles output disable only during test or initialization.
// R15 - Each channel has its own output disable acting on its bus only.
// R16 - Shutdown low runs; high with disable high sleeps; high with disable low naps.
// R17 - Leaving sleep waits a reference recharge window before data is valid.
// R18 - Leaving nap gives valid data after about a hundred sample clock edges.
// R19 - Sleep and nap float all digital outputs of that channel.
// R20 - Power and disable states of the two channels are independent.
// R21 - Swap high puts A on first bus, B on second; low reverses them.
// R22 - Board ties swap and both clocks together to share one bus.
// R23 - Shared-bus mode presents A and B alternately, one clock phase each.
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module dao_top #(
	parameter int SLEEP_WAKE_CYC = dao_pkg::SLEEP_WAKE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [dao_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sample_clock_a_i,
	input wire logic sample_clock_b_i,
	input wire logic [1:0] mode_level_i,
	input wire logic output_disable_n_a_i,
	input wire logic output_disable_n_b_i,
	input wire logic power_down_a_i,
	input wire logic power_down_b_i,
	input wire logic bus_swap_select_i,
	input wire logic signed [dao_pkg::RAW_W-1:0] analog_a_i,
	input wire logic signed [dao_pkg::RAW_W-1:0] analog_b_i,
	output logic [dao_pkg::DATA_W-1:0] first_output_bus_o,
	output logic first_output_bus_oe_n_o,
	output logic [dao_pkg::DATA_W-1:0] second_output_bus_o,
	output logic second_output_bus_oe_n_o,
	output logic overflow_flag_a_o,
	output logic overflow_flag_a_oe_n_o,
	output logic overflow_flag_b_o,
	output logic overflow_flag_b_oe_n_o,
	output logic data_strobe_out_o,
	output logic data_strobe_out_oe_n_o
);
	import dao_pkg::*;

	// ==========================================================
	// Pin resynchronisers
	logic [1:0] sclk, pd_in, dis_in;
	logic [1:0] clk_s1, clk_s2, clk_s3, pd_s1, pd_s2, dis_s1, dis_s2;
	logic [1:0] mode_s1, mode_s2;
	logic swap_s1, swap_s2;
	logic signed [RAW_W-1:0] raw_in [2];
	logic signed [RAW_W-1:0] raw_s1 [2];
	logic signed [RAW_W-1:0] raw_s2 [2];
	logic [1:0] rise;
	logic dcs_on, twos;
	logic hs_reg;

	assign sclk = {sample_clock_b_i, sample_clock_a_i};
	assign pd_in = {power_down_b_i, power_down_a_i};
	assign dis_in = {output_disable_n_b_i, output_disable_n_a_i};
	assign raw_in[0] = analog_a_i;
	assign raw_in[1] = analog_b_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_s1 <= MODE_GND;
			mode_s2 <= MODE_GND;
			swap_s1 <= 1'b0;
			swap_s2 <= 1'b0;
		end else begin
			mode_s1 <= mode_level_i;
			mode_s2 <= mode_s1;
			swap_s1 <= bus_swap_select_i;
			swap_s2 <= swap_s1;
		end
	end

	// Middle levels turn the stabilizer on; upper half selects two's complement
	assign dcs_on = (mode_s2 == MODE_THIRD) || (mode_s2 == MODE_TWO_THIRD); // R6
	assign twos = (mode_s2 == MODE_TWO_THIRD) || (mode_s2 == MODE_SUPPLY); // R6

	// ==========================================================
	// Per-channel clock, stabilizer, power and capture
	logic [PER_W-1:0] per_cnt_reg [2];
	logic [PER_W-1:0] per_reg [2];
	logic [6:0] lock_cnt_reg [2];
	logic [WAKE_W-1:0] wake_cnt_reg [2];
	dao_pwr_t pwr_reg [2];
	logic [1:0] phase_reg, wake_sleep_reg, of_reg, slow, locked, act, hz, valid;
	logic [DATA_W-1:0] word_reg [2];

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_ch
			logic [DATA_W-1:0] clamp_next;
			logic over_next;
			logic [PER_W-1:0] half;

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					clk_s1[c] <= 1'b0;
					clk_s2[c] <= 1'b0;
					clk_s3[c] <= 1'b0;
					pd_s1[c] <= 1'b0;
					pd_s2[c] <= 1'b0;
					dis_s1[c] <= 1'b1;
					dis_s2[c] <= 1'b1;
					raw_s1[c] <= '0;
					raw_s2[c] <= '0;
				end else begin
					clk_s1[c] <= sclk[c];
					clk_s2[c] <= clk_s1[c];
					clk_s3[c] <= clk_s2[c];
					pd_s1[c] <= pd_in[c];
					pd_s2[c] <= pd_s1[c];
					dis_s1[c] <= dis_in[c];
					dis_s2[c] <= dis_s1[c];
					raw_s1[c] <= raw_in[c];
					raw_s2[c] <= raw_s1[c];
				end
			end

			// Only the rising edge of the incoming clock is used for sampling; with the stabilizer off the phase copies the input
			assign rise[c] = clk_s2[c] & ~clk_s3[c]; // R2

			// Period in system cycles; saturation marks a stopped or too slow clock
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					per_cnt_reg[c] <= '0;
					per_reg[c] <= '0;
				end else if (rise[c]) begin
					per_cnt_reg[c] <= '0;
					per_reg[c] <= per_cnt_reg[c] + PER_W'(1);
				end else if (per_cnt_reg[c] != PER_W'(CLK_STOP_CYC)) begin
					per_cnt_reg[c] <= per_cnt_reg[c] + PER_W'(1);
				end
			end
			assign slow[c] = (per_cnt_reg[c] == PER_W'(CLK_STOP_CYC)); // R1

			// Relock needs a full run of edges after any stop long enough to saturate the period count
			always_ff @(posedge clk_i) begin
				if (rst_i || slow[c] || !dcs_on) begin
					lock_cnt_reg[c] <= '0; // R4
				end else if (rise[c] && lock_cnt_reg[c] != 7'(LOCK_EDGES)) begin
					lock_cnt_reg[c] <= lock_cnt_reg[c] + 7'h01; // R4
				end
			end
			assign locked[c] = !dcs_on || (lock_cnt_reg[c] == 7'(LOCK_EDGES));

			// Internal phase: stabilizer on, falls at half the measured period, whatever the input duty; off, follows the input
			assign half = per_reg[c] >> 1;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					phase_reg[c] <= 1'b0;
				end else if (!dcs_on) begin
					phase_reg[c] <= clk_s2[c];
				end else if (rise[c]) begin
					phase_reg[c] <= 1'b1; // R3
				end else if (slow[c] || per_cnt_reg[c] + PER_W'(1) >= half) begin
					phase_reg[c] <= 1'b0; // R3
				end
			end

			// Power modes; sleep exit is timed in system cycles, nap exit in edges
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pwr_reg[c] <= PWR_RUN;
					wake_sleep_reg[c] <= 1'b0;
					wake_cnt_reg[c] <= '0;
				end else begin
					unique case (pwr_reg[c])
						PWR_RUN, PWR_WAKE: begin
							if (pd_s2[c]) begin
								pwr_reg[c] <= dis_s2[c] ? PWR_SLEEP : PWR_NAP; // R16
								if (dis_s2[c]) begin
									wake_sleep_reg[c] <= 1'b1;
								end
							end else if (pwr_reg[c] == PWR_WAKE) begin
								if (wake_sleep_reg[c]) begin
									wake_cnt_reg[c] <= wake_cnt_reg[c] + WAKE_W'(1);
									if (wake_cnt_reg[c] + WAKE_W'(1) >= WAKE_W'(SLEEP_WAKE_CYC)) begin
										pwr_reg[c] <= PWR_RUN; // R17
										wake_sleep_reg[c] <= 1'b0;
									end
								end else if (rise[c]) begin
									wake_cnt_reg[c] <= wake_cnt_reg[c] + WAKE_W'(1);
									if (wake_cnt_reg[c] + WAKE_W'(1) >= WAKE_W'(NAP_WAKE_EDGES)) begin
										pwr_reg[c] <= PWR_RUN; // R18
									end
								end
							end
						end
						PWR_NAP, PWR_SLEEP: begin
							wake_cnt_reg[c] <= '0;
							if (!pd_s2[c]) begin
								pwr_reg[c] <= PWR_WAKE;
							end else if (dis_s2[c]) begin
								pwr_reg[c] <= PWR_SLEEP; // R16
								wake_sleep_reg[c] <= 1'b1;
							end else begin
								pwr_reg[c] <= PWR_NAP; // R16
							end
						end
					endcase
				end
			end
			assign act[c] = (pwr_reg[c] == PWR_RUN) || (pwr_reg[c] == PWR_WAKE);
			// Each channel floats on its own disable or its own low-power state
			assign hz[c] = dis_s2[c] || !act[c]; // R13 R15 R19 R20
			assign valid[c] = (pwr_reg[c] == PWR_RUN) && locked[c] && !slow[c];

			// Clamp and code the conversion result
			always_comb begin
				clamp_next = raw_s2[c][DATA_W-1:0];
				over_next = 1'b0;
				if (raw_s2[c] > RAW_MAX) begin
					clamp_next = CODE_POS_FULL; // R7
					over_next = 1'b1;
				end else if (raw_s2[c] < RAW_MIN) begin
					clamp_next = CODE_NEG_FULL; // R7
					over_next = 1'b1;
				end
				if (!twos) begin
					clamp_next = clamp_next ^ CODE_MSB_FLIP; // R7
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					word_reg[c] <= '0;
					of_reg[c] <= 1'b0;
				end else if (rise[c] && act[c]) begin
					word_reg[c] <= clamp_next; // R2
					of_reg[c] <= over_next;
				end
			end

			a_zero_code: assert property (@(posedge clk_i) disable iff (rst_i) // R7
				rise[c] && act[c] && raw_s2[c] == 16'sh0000 |=> word_reg[c] == (twos ? 14'h0000 : 14'h2000))
				else $error("zero input not coded as midscale");
			a_clamp_high: assert property (@(posedge clk_i) disable iff (rst_i) // R7
				rise[c] && act[c] && raw_s2[c] > RAW_MAX && $stable(mode_s2)
				|=> of_reg[c] && word_reg[c] == (twos ? 14'h1FFF : 14'h3FFF))
				else $error("overrange not clamped to full scale");
			a_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i) // R16
				pwr_reg[c] == PWR_RUN && pd_s2[c] && dis_s2[c] |=> pwr_reg[c] == PWR_SLEEP)
				else $error("shutdown with disable high did not sleep");
			a_nap_exit: assert property (@(posedge clk_i) disable iff (rst_i) // R18
				pwr_reg[c] == PWR_NAP && !pd_s2[c] && !wake_sleep_reg[c]
				|=> pwr_reg[c] == PWR_WAKE ##1 (pwr_reg[c] == PWR_WAKE || pd_s2[c])[*8])
				else $error("nap exit did not hold in recovery");
			a_dcs_phase: assert property (@(posedge clk_i) disable iff (rst_i) // R3
				dcs_on && rise[c] && $stable(mode_s2) |=> phase_reg[c] ##1 (phase_reg[c] || half <= PER_W'(1)))
				else $error("stabilizer phase did not rise on input edge");
			a_relock: assert property (@(posedge clk_i) disable iff (rst_i) // R4
				dcs_on && slow[c] |=> !locked[c])
				else $error("lock kept across a stopped clock");
		end
	endgenerate

	// ==========================================================
	// Output pins, all from flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_output_bus_o <= '0;
			second_output_bus_o <= '0;
			first_output_bus_oe_n_o <= 1'b1;
			second_output_bus_oe_n_o <= 1'b1;
		end else begin
			// Tied to the clocks, the swap input alternates A and B each phase
			first_output_bus_o <= swap_s2 ? word_reg[0] : word_reg[1]; // R21 R23
			second_output_bus_o <= swap_s2 ? word_reg[1] : word_reg[0]; // R21
			first_output_bus_oe_n_o <= swap_s2 ? hz[0] : hz[1]; // R15
			second_output_bus_oe_n_o <= swap_s2 ? hz[1] : hz[0]; // R15
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_flag_a_o <= 1'b0;
			overflow_flag_a_oe_n_o <= 1'b1;
			overflow_flag_b_o <= 1'b0;
			overflow_flag_b_oe_n_o <= 1'b1;
		end else if (hs_reg) begin
			overflow_flag_a_o <= of_reg[0] | of_reg[1]; // R8
			overflow_flag_a_oe_n_o <= hz[0]; // R9 R13
			overflow_flag_b_o <= 1'b0;
			overflow_flag_b_oe_n_o <= 1'b1;
		end else begin
			overflow_flag_a_o <= of_reg[0]; // R10
			overflow_flag_a_oe_n_o <= hz[0]; // R13
			overflow_flag_b_o <= of_reg[1]; // R10
			overflow_flag_b_oe_n_o <= hz[1]; // R13
		end
	end

	// Strobe lags channel B phase by one cycle; data changed on the rise so a falling capture is safe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_strobe_out_o <= 1'b0;
			data_strobe_out_oe_n_o <= 1'b1;
		end else begin
			data_strobe_out_o <= phase_reg[1]; // R11
			data_strobe_out_oe_n_o <= !hs_reg || !act[1]; // R12
		end
	end

	a_swap_route: assert property (@(posedge clk_i) disable iff (rst_i) // R21
		swap_s2 |=> first_output_bus_o == $past(word_reg[0]) && second_output_bus_o == $past(word_reg[1]))
		else $error("swap high did not route A to first bus");
	a_swap_low: assert property (@(posedge clk_i) disable iff (rst_i) // R21
		!swap_s2 |=> first_output_bus_o == $past(word_reg[1]) && first_output_bus_oe_n_o == $past(hz[1]))
		else $error("swap low did not route B to first bus");
	a_shared_of: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		hs_reg && (of_reg[0] || of_reg[1]) |=> overflow_flag_a_o)
		else $error("shared overflow missed a channel");
	a_of_float: assert property (@(posedge clk_i) disable iff (rst_i) // R9
		pwr_reg[0] == PWR_NAP || pwr_reg[0] == PWR_SLEEP |=> overflow_flag_a_oe_n_o)
		else $error("overflow driven while channel A powered down");
	a_strobe_float: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		pwr_reg[1] == PWR_NAP || pwr_reg[1] == PWR_SLEEP |=> data_strobe_out_oe_n_o)
		else $error("strobe driven while channel B powered down");
	a_strobe_copy: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		$rose(phase_reg[1]) |=> $rose(data_strobe_out_o))
		else $error("strobe not a delayed copy of channel B phase");

	// ==========================================================
	// Wishbone slave: one wait state, every address acknowledged
	logic req;
	logic [31:0] status;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign status = {19'h00000, swap_s2, twos, dcs_on, slow, locked, valid, pwr_reg[1], pwr_reg[0]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hs_reg <= CTRL_HS_RST;
		end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
			hs_reg <= wb_dat_i[CTRL_HS_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (req) begin
			unique case (wb_adr_i)
				ADR_CTRL: wb_dat_o <= {31'h00000000, hs_reg};
				ADR_STATUS: wb_dat_o <= status;
				ADR_WORD_A: wb_dat_o <= {17'h00000, of_reg[0], word_reg[0]};
				ADR_WORD_B: wb_dat_o <= {17'h00000, of_reg[1], word_reg[1]};
				default: wb_dat_o <= '0;
			endcase
		end
	end

	a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");
endmodule

// ===== verification/dao_capture_model.sv
// Purpose: Far-side capture logic that clocks the converter and latches its words
// Assumes: One sample clock feeds both channels, 5 Msps, 50% duty
// Notes: Captures only while both the strobe and the bus are driven; stop_i holds the clock level
`timescale 1ns/100ps
module dao_capture_model (
	input wire logic stop_i,
	output logic sample_clock_o,
	input wire logic data_strobe_i,
	input wire logic data_strobe_oe_n_i,
	input wire logic [dao_pkg::DATA_W-1:0] bus_i,
	input wire logic bus_oe_n_i,
	output logic [dao_pkg::DATA_W-1:0] cap_word_o,
	output logic cap_seen_o
);
	import dao_pkg::*;
	// ==========================================================
	// Sample clock, free running unless paused to force a stabilizer relock
	initial begin
		sample_clock_o = 1'b0;
		#7;
		forever begin
			#100;
			if (!stop_i) begin
				sample_clock_o = ~sample_clock_o;
			end
		end
	end
	// ==========================================================
	// Latch on the falling strobe edge, where data has settled
	always @(negedge data_strobe_i) begin
		if (!data_strobe_oe_n_i && !bus_oe_n_i) begin
			cap_word_o <= bus_i;
			cap_seen_o <= 1'b1;
		end
	end
endmodule

// ===== verification/dao_top_test.sv
// Purpose: Self-checking bench for the converter output and power block
// Assumes: Short sleep recovery count so the run stays brief
// Notes: Register reads go through a classic Wishbone master task
`timescale 1ns/100ps
module dao_top_test;
	import dao_pkg::*;
	localparam int SLEEP_CYC = 50;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [ADR_W-1:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rdat, rd;
	logic ack, sclk;
	logic stop = 1'b0;
	logic [1:0] mode = 2'h0;
	logic dis_n_a = 1'b0, dis_n_b = 1'b0, pd_a = 1'b0, pd_b = 1'b0, swap = 1'b1;
	logic signed [RAW_W-1:0] ana_a = '0, ana_b = '0;
	logic [DATA_W-1:0] bus1, bus2, cap;
	logic bus1_oe_n, bus2_oe_n, of_a, of_a_oe_n, of_b, of_b_oe_n, strb, strb_oe_n, cap_seen;
	logic signed [RAW_W-1:0] vals [5] = '{16'sh0000, 16'sh1FFF, 16'sh2000, 16'shE000, 16'shDFFF};
	logic [14:0] e;
	int failures = 0, cmp_count = 0, m, i, s;
	always #12.5 clk = ~clk;
	dao_top #(.SLEEP_WAKE_CYC(SLEEP_CYC)) uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.sample_clock_a_i(sclk), .sample_clock_b_i(sclk), .mode_level_i(mode),
		.output_disable_n_a_i(dis_n_a), .output_disable_n_b_i(dis_n_b), .power_down_a_i(pd_a),
		.power_down_b_i(pd_b), .bus_swap_select_i(swap), .analog_a_i(ana_a), .analog_b_i(ana_b),
		.first_output_bus_o(bus1), .first_output_bus_oe_n_o(bus1_oe_n), .second_output_bus_o(bus2),
		.second_output_bus_oe_n_o(bus2_oe_n), .overflow_flag_a_o(of_a), .overflow_flag_a_oe_n_o(of_a_oe_n),
		.overflow_flag_b_o(of_b), .overflow_flag_b_oe_n_o(of_b_oe_n), .data_strobe_out_o(strb),
		.data_strobe_out_oe_n_o(strb_oe_n));
	dao_capture_model partner (.stop_i(stop), .sample_clock_o(sclk), .data_strobe_i(strb),
		.data_strobe_oe_n_i(strb_oe_n),
		.bus_i(bus1), .bus_oe_n_i(bus1_oe_n), .cap_word_o(cap), .cap_seen_o(cap_seen));
	// ==========================================================
	// Compare and bus tasks
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		chk1(ack, 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pwr(input int bit_lo, input logic [1:0] exp);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk32({30'h0, rd[bit_lo+:2]}, {30'h0, exp});
	endtask
	// Clamp first, then flip the sign bit for offset binary
	function automatic logic [14:0] exp_word(input logic signed [RAW_W-1:0] v, input logic twos);
		logic signed [RAW_W-1:0] c;
		c = (v > RAW_MAX) ? RAW_MAX : ((v < RAW_MIN) ? RAW_MIN : v);
		return {(v > RAW_MAX) || (v < RAW_MIN), c[13:0] ^ (twos ? 14'h0000 : CODE_MSB_FLIP)};
	endfunction
	task automatic results;
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========================================================
	// Watchdog, about six times the expected run
	initial begin
		#(25 * 20000);
		failures++;
		results();
	end
	// ==========================================================
	// Test sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, ADR_CTRL, 32'h0);
		chk1(rd[CTRL_HS_BIT], CTRL_HS_RST);
		wb(1'b0, 8'h10, 32'h0);
		chk32(rd, 32'h0);
		for (m = 0; m < 4; m++) begin
			mode <= m[1:0];
			for (i = 0; i < 5; i++) begin
				ana_a <= vals[i];
				wait_clk(40);
				e = exp_word(vals[i], m[1]);
				wb(1'b0, ADR_WORD_A, 32'h0);
				chk32(rd & 32'h7FFF, {17'h0, e});
				chk1(of_a, e[14]);
			end
			wb(1'b0, ADR_STATUS, 32'h0);
			chk1(rd[ST_TWOS], m[1]);
			chk1(rd[ST_DCS], m[1] ^ m[0]);
		end
		// Pause the sample clock with the stabilizer on, then let it relock
		mode <= MODE_THIRD;
		stop <= 1'b1;
		wait_clk(60);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk1(rd[ST_SLOW], 1'b1);
		chk1(rd[ST_LOCK], 1'b0);
		stop <= 1'b0;
		wait_clk(900);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk1(rd[ST_LOCK], 1'b1);
		chk1(rd[ST_VALID], 1'b1);
		mode <= MODE_GND;
		wb(1'b1, ADR_CTRL, 32'h0);
		ana_a <= 16'sh0000;
		ana_b <= 16'sh7000;
		wait_clk(40);
		chk1(of_a, 1'b0);
		chk1(of_b, 1'b1);
		chk1(of_b_oe_n, 1'b0);
		chk1(strb_oe_n, 1'b1);
		wb(1'b0, ADR_WORD_B, 32'h0);
		chk32(rd & 32'h7FFF, {17'h0, exp_word(16'sh7000, 1'b0)});
		wb(1'b1, ADR_CTRL, 32'h1);
		wait_clk(8);
		chk1(of_a, 1'b1);
		chk1(of_b_oe_n, 1'b1);
		ana_a <= 16'sh0064;
		ana_b <= 16'shFF9C;
		for (s = 0; s < 2; s++) begin
			swap <= s[0];
			wait_clk(40);
			chk32({18'h0, bus1}, {17'h0, exp_word(s[0] ? 16'sh0064 : 16'shFF9C, 1'b0)});
			chk32({18'h0, bus2}, {17'h0, exp_word(s[0] ? 16'shFF9C : 16'sh0064, 1'b0)});
		end
		chk1(strb_oe_n, 1'b0);
		chk1(cap_seen, 1'b1);
		chk32({18'h0, cap}, {17'h0, exp_word(16'sh0064, 1'b0)});
		// Disable is toggled only between tests, never mid capture
		dis_n_a <= 1'b1;
		wait_clk(10);
		chk1(bus1_oe_n, 1'b1);
		chk1(of_a_oe_n, 1'b1);
		chk1(bus2_oe_n, 1'b0);
		dis_n_a <= 1'b0;
		wait_clk(10);
		pd_b <= 1'b1;
		wait_clk(10);
		pwr(ST_PWR_B, 2'h1);
		chk1(bus2_oe_n, 1'b1);
		chk1(strb_oe_n, 1'b1);
		chk1(bus1_oe_n, 1'b0);
		chk1(of_a_oe_n, 1'b0);
		pd_b <= 1'b0;
		wait_clk(10);
		pwr(ST_PWR_B, 2'h2);
		wait_clk(640);
		pwr(ST_PWR_B, 2'h2);
		wait_clk(320);
		pwr(ST_PWR_B, 2'h0);
		chk1(bus2_oe_n, 1'b0);
		dis_n_a <= 1'b1;
		pd_a <= 1'b1;
		wait_clk(10);
		pwr(ST_PWR_A, 2'h3);
		chk1(of_a_oe_n, 1'b1);
		chk1(bus2_oe_n, 1'b0);
		pd_a <= 1'b0;
		dis_n_a <= 1'b0;
		wait_clk(10);
		pwr(ST_PWR_A, 2'h2);
		wait_clk(SLEEP_CYC + 20);
		pwr(ST_PWR_A, 2'h0);
		results();
	end
endmodule
